// ==== src/flc_fuse_lock_config.sv ====
// Purpose: fuse and lock cell store, fuse latching, signature read-out,
//   oscillator calibration load and boot section access checking
// Assumes: programmer command strobes come from logic on clk
// Notes: programming mode entry is a pin, filtered by three flops
// Contract
// - Boot mode 1 puts no limit on program stores or loads to boot.
// - Boot mode 2 blocks program stores into the boot section.
// - Boot mode 3 blocks boot stores and boot loads from application code.
// - Boot mode 4 blocks boot loads from application code, allows stores.
// - Modes 3 and 4, vectors in application: no interrupts in boot code.
// - Programmed cells are 0, unprogrammed are 1, read back as stored.
// - Extended byte: clock-fail disable, brown-out level, top nibble ones.
// - High byte: reset disable, debug, serial enable, watchdog forced.
// - High byte: eeprom keep, boot size, reset vector select.
// - Serial enable fuse hidden and unwritable in serial programming.
// - Low byte bit 6 programmed routes clock to port B pin zero.
// - Clock source default 0010 internal RC, bit 7 divide by eight.
// - Start-up select default 10 gives longest start-up.
// - Boot size default both programmed, largest boot section.
// - Chip erase leaves all fuse cells unchanged.
// - Memory lock bit a programmed freezes all fuse cells.
// - Fuses latch at programming entry, new values apply at exit.
// - Eeprom keep fuse acts at once when programmed.
// - Fuses also latch at power-up in normal mode.
// - Three signature bytes readable always, even when locked.
// - Reset loads calibration byte into oscillator calibration register.
// - Lock cells return to one only through chip erase.
`timescale 1ns/1ps
module flc_fuse_lock_config #(
    parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE2 = 8'h21, // Arbitrary identity value
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic progModePin,
    input wire logic serialMode,
    input wire logic fuseWrStb,
    input wire flc_pkg::flc_fuse_sel_t fuseWrSel,
    input wire logic [7:0] fuseWrData,
    input wire logic lockWrStb,
    input wire logic [7:0] lockWrData,
    input wire logic chipEraseStb,
    input wire logic rdStb,
    input wire flc_pkg::flc_space_t rdSpace,
    input wire logic [1:0] rdAddr,
    output logic [7:0] rdData,
    output logic rdValid,
    input wire logic storeProgramInstr,
    input wire logic loadProgramInstr,
    input wire logic accessInBoot,
    input wire logic execInBoot,
    input wire logic vectorsInBoot,
    output logic storeBlocked,
    output logic loadBlocked,
    output logic irqDisable,
    input wire logic oscCalWrStb,
    input wire logic [7:0] oscCalWrData,
    output logic [7:0] rcOscCalibrationReg,
    output logic clockFailDetectDisable,
    output logic [2:0] brownoutLevelSel,
    output logic extResetDisable,
    output logic oneWireDebugEnable,
    output logic serialProgEnable,
    output logic watchdogForcedOn,
    output logic eepromKeepOnErase,
    output logic [1:0] bootSizeSel,
    output logic resetVectorSel,
    output logic clockDivByEight,
    output logic clockOutputEnable,
    output logic [1:0] startupTimeSel,
    output logic [3:0] clockSourceSel,
    output logic inProgMode
);
    import flc_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Declarations
    logic [2:0] progSync_reg;
    logic progMode_reg;
    flc_state_t state_reg;
    flc_state_t state_next;
    logic [7:0] extNv_reg;
    logic [7:0] highNv_reg;
    logic [7:0] lowNv_reg;
    logic [7:0] lockNv_reg;
    logic [7:0] extAct_reg;
    logic [7:0] highAct_reg;
    logic [7:0] lowAct_reg;
    logic keep_reg;
    logic latchNow;
    logic fuseWrOk;
    flc_boot_mode_t bootMode;
    logic [7:0] highRead;
    logic [7:0] lockMasked;

    ////////////////////////////////////////////////////////////////
    // Pin filter: change counts once second and third flop agree
    always_ff @(posedge clk) begin
        if (reset) begin
            progSync_reg <= 3'h0;
        end else begin
            progSync_reg <= {progSync_reg[1:0], progModePin};
        end
    end

    // Filtered programming mode level
    always_ff @(posedge clk) begin
        if (reset) begin
            progMode_reg <= 1'b0;
        end else if (progSync_reg[1] == progSync_reg[2]) begin
            progMode_reg <= progSync_reg[2];
        end
    end

    assign inProgMode = (state_reg == ST_PROG);

    ////////////////////////////////////////////////////////////////
    // Latch sequencer: boot latch, entry latch, exit latch
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_BOOT: state_next = ST_NORMAL;
            ST_NORMAL: begin
                if (progMode_reg) begin
                    state_next = ST_PROG;
                end
            end
            ST_PROG: begin
                if (!progMode_reg) begin
                    state_next = ST_EXIT;
                end
            end
            ST_EXIT: state_next = ST_NORMAL;
            default: state_next = ST_BOOT;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_BOOT;
        end else begin
            state_reg <= state_next;
        end
    end

    assign latchNow = (state_reg == ST_BOOT) || (state_reg == ST_EXIT) ||
                      ((state_reg == ST_NORMAL) && progMode_reg);

    ////////////////////////////////////////////////////////////////
    // Fuse cells; reset stands for a blank part at power-on
    // lock bit a freezes fuses
    assign fuseWrOk = fuseWrStb && (state_reg == ST_PROG) && lockNv_reg[LOCK_A_BIT];

    // chip erase does not touch fuses
    // extended top nibble always reads ones
    always_ff @(posedge clk) begin
        if (reset) begin
            extNv_reg <= EXT_DEFAULT;
            lowNv_reg <= LOW_DEFAULT;
        end else if (fuseWrOk) begin
            if (fuseWrSel == FUSE_EXT) begin
                extNv_reg <= fuseWrData | EXT_FIXED_ONES;
            end
            if (fuseWrSel == FUSE_LOW) begin
                lowNv_reg <= fuseWrData;
            end
        end
    end

    // serial enable cell kept in serial mode
    always_ff @(posedge clk) begin
        if (reset) begin
            highNv_reg <= HIGH_DEFAULT;
        end else if (fuseWrOk && (fuseWrSel == FUSE_HIGH)) begin
            highNv_reg <= fuseWrData;
            if (serialMode) begin
                highNv_reg[HIGH_SPI_BIT] <= highNv_reg[HIGH_SPI_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Lock cells: writes only program, erase only unprograms
    // Lock bit b also freezes the boot lock field
    assign lockMasked = lockNv_reg[LOCK_B_BIT] ? lockWrData : (lockWrData | LOCK_BOOT_MASK);

    // return to one only by erase
    always_ff @(posedge clk) begin
        if (reset) begin
            lockNv_reg <= LOCK_DEFAULT;
        end else if (chipEraseStb && (state_reg == ST_PROG)) begin
            lockNv_reg <= LOCK_DEFAULT;
        end else if (lockWrStb && (state_reg == ST_PROG)) begin
            lockNv_reg <= lockNv_reg & lockMasked;
        end
    end

    ////////////////////////////////////////////////////////////////
    // active copies hold until next latch
    always_ff @(posedge clk) begin
        if (reset) begin
            extAct_reg <= EXT_DEFAULT;
            highAct_reg <= HIGH_DEFAULT;
            lowAct_reg <= LOW_DEFAULT;
        end else if (latchNow) begin
            extAct_reg <= extNv_reg;
            highAct_reg <= highNv_reg;
            lowAct_reg <= lowNv_reg;
        end
    end

    // eeprom keep set one clock after the cell is programmed, cleared only once cell and active copy are both unprogrammed
    always_ff @(posedge clk) begin
        if (reset) begin
            keep_reg <= 1'b0;
        end else begin
            keep_reg <= ~(highNv_reg[HIGH_KEEP_BIT] & highAct_reg[HIGH_KEEP_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////
    // decoded configuration, low active cells
    assign clockFailDetectDisable = ~extAct_reg[EXT_CLKFAIL_BIT];
    assign brownoutLevelSel = extAct_reg[EXT_BOD_MSB:EXT_BOD_LSB];
    assign extResetDisable = ~highAct_reg[HIGH_RST_BIT];
    assign oneWireDebugEnable = ~highAct_reg[HIGH_DBG_BIT];
    assign serialProgEnable = ~highAct_reg[HIGH_SPI_BIT];
    assign watchdogForcedOn = ~highAct_reg[HIGH_WDT_BIT];
    assign eepromKeepOnErase = keep_reg;
    assign bootSizeSel = highAct_reg[HIGH_BOOTSIZE_MSB:HIGH_BOOTSIZE_LSB];
    assign resetVectorSel = highAct_reg[HIGH_RSTVEC_BIT];
    assign clockDivByEight = ~lowAct_reg[LOW_DIV8_BIT];
    assign clockOutputEnable = ~lowAct_reg[LOW_CLKOUT_BIT];
    assign startupTimeSel = lowAct_reg[LOW_START_MSB:LOW_START_LSB];
    assign clockSourceSel = lowAct_reg[LOW_CLKSRC_MSB:LOW_CLKSRC_LSB];

    ////////////////////////////////////////////////////////////////
    // Boot lock mode from the cells, effective at once
    always_comb begin
        case ({lockNv_reg[BOOT_HI_BIT], lockNv_reg[BOOT_LO_BIT]})
            2'b11: bootMode = BMODE1;
            2'b10: bootMode = BMODE2;
            2'b00: bootMode = BMODE3;
            default: bootMode = BMODE4;
        endcase
    end

    assign storeBlocked = storeProgramInstr && accessInBoot &&
                          ((bootMode == BMODE2) || (bootMode == BMODE3));
    assign loadBlocked = loadProgramInstr && accessInBoot && !execInBoot &&
                         ((bootMode == BMODE3) || (bootMode == BMODE4));
    assign irqDisable = execInBoot && !vectorsInBoot &&
                        ((bootMode == BMODE3) || (bootMode == BMODE4));

    ////////////////////////////////////////////////////////////////
    // serial enable cell reads as one in serial mode
    always_comb begin
        highRead = highNv_reg;
        if (serialMode) begin
            highRead[HIGH_SPI_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdData <= 8'h00;
        end else if (rdStb) begin
            case (rdSpace)
                SPACE_SIG: begin
                    case (rdAddr)
                        SIG_OFS0: rdData <= SIG_BYTE0;
                        SIG_OFS1: rdData <= SIG_BYTE1;
                        SIG_OFS2: rdData <= SIG_BYTE2;
                        default: rdData <= 8'h00;
                    endcase
                end
                SPACE_FUSE: begin
                    case (rdAddr)
                        2'h0: rdData <= lowNv_reg;
                        2'h1: rdData <= highRead;
                        2'h2: rdData <= extNv_reg;
                        default: rdData <= 8'h00;
                    endcase
                end
                SPACE_LOCK: rdData <= lockNv_reg;
                SPACE_CAL: rdData <= CAL_BYTE;
                default: rdData <= 8'h00;
            endcase
        end
    end

    // One-cycle answer strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdStb;
        end
    end

    ////////////////////////////////////////////////////////////////
    // calibration loaded during reset, software may retune
    always_ff @(posedge clk) begin
        if (reset) begin
            rcOscCalibrationReg <= CAL_BYTE;
        end else if (oscCalWrStb) begin
            rcOscCalibrationReg <= oscCalWrData;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    sequence s_entry;
        (state_reg == ST_NORMAL) && progMode_reg;
    endsequence

    sequence s_inprog;
        (state_reg == ST_PROG) && progMode_reg;
    endsequence

    property p_mode1_free;
        @(posedge clk) disable iff (reset)
        (bootMode == BMODE1) |-> (!storeBlocked && !loadBlocked && !irqDisable);
    endproperty
    a_mode1_free: assert property (p_mode1_free) else $error("mode 1 restricted access");
    property p_store_block;
        @(posedge clk) disable iff (reset)
        (storeProgramInstr && accessInBoot) |->
            (storeBlocked == ((bootMode == BMODE2) || (bootMode == BMODE3)));
    endproperty
    a_store_block: assert property (p_store_block) else $error("boot store check wrong");
    property p_load_block;
        @(posedge clk) disable iff (reset)
        (loadProgramInstr && accessInBoot && !execInBoot) |->
            (loadBlocked == ((bootMode == BMODE3) || (bootMode == BMODE4)));
    endproperty
    a_load_block: assert property (p_load_block) else $error("boot load check wrong");
    property p_irq_off;
        @(posedge clk) disable iff (reset)
        (execInBoot && !vectorsInBoot && (bootMode == BMODE3)) |-> irqDisable;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupts not disabled");
    property p_erase_fuses;
        @(posedge clk) disable iff (reset)
        (chipEraseStb && !fuseWrStb) |=> ($stable(highNv_reg) && $stable(lowNv_reg) && $stable(extNv_reg));
    endproperty
    a_erase_fuses: assert property (p_erase_fuses) else $error("erase changed fuses");
    property p_fuse_frozen;
        @(posedge clk) disable iff (reset)
        !lockNv_reg[LOCK_A_BIT] |=> ($stable(highNv_reg) && $stable(lowNv_reg) && $stable(extNv_reg));
    endproperty
    a_fuse_frozen: assert property (p_fuse_frozen) else $error("fuse changed while locked");
    property p_serial_hidden;
        @(posedge clk) disable iff (reset)
        (fuseWrStb && serialMode) |=> $stable(highNv_reg[HIGH_SPI_BIT]);
    endproperty
    a_serial_hidden: assert property (p_serial_hidden) else $error("serial enable written");
    property p_hold_in_prog;
        @(posedge clk) disable iff (reset)
        s_inprog ##1 s_inprog |-> ($stable(lowAct_reg) && $stable(highAct_reg) && $stable(extAct_reg));
    endproperty
    a_hold_in_prog: assert property (p_hold_in_prog) else $error("active fuses moved in prog");
    property p_entry_latch;
        @(posedge clk) disable iff (reset)
        s_entry |=> (lowAct_reg == $past(lowNv_reg)) && (highAct_reg == $past(highNv_reg));
    endproperty
    a_entry_latch: assert property (p_entry_latch) else $error("entry latch missed");
    property p_keep_now;
        @(posedge clk) disable iff (reset)
        $fell(highNv_reg[HIGH_KEEP_BIT]) |=> eepromKeepOnErase [*2];
    endproperty
    a_keep_now: assert property (p_keep_now) else $error("eeprom keep late");
    property p_sig_read;
        @(posedge clk) disable iff (reset)
        (rdStb && (rdSpace == SPACE_SIG) && (rdAddr == SIG_OFS2)) |=> (rdValid && (rdData == SIG_BYTE2));
    endproperty
    a_sig_read: assert property (p_sig_read) else $error("signature read wrong");
    property p_lock_one_way;
        @(posedge clk) disable iff (reset)
        !chipEraseStb |=> ((lockNv_reg & ~$past(lockNv_reg)) == 8'h00);
    endproperty
    a_lock_one_way: assert property (p_lock_one_way) else $error("lock unprogrammed");
    property p_cal_load;
        @(posedge clk)
        reset ##1 !reset |-> (rcOscCalibrationReg == CAL_BYTE);
    endproperty
    a_cal_load: assert property (p_cal_load) else $error("calibration not loaded");

endmodule // flc_fuse_lock_config

// ==== src/flc_pkg.sv ====
// Purpose: shared constants for the fuse and lock configuration block
// Assumes: programmed cell reads 0, unprogrammed reads 1
// Notes: bit positions, defaults and encodings live here only
package flc_pkg;

    ////////////////////////////////////////////////////////////////
    // Fuse byte defaults as shipped
    localparam logic [7:0] EXT_DEFAULT = 8'hf7;
    localparam logic [7:0] HIGH_DEFAULT = 8'hd9;
    localparam logic [7:0] LOW_DEFAULT = 8'h62;
    localparam logic [7:0] LOCK_DEFAULT = 8'hff;
    localparam logic [7:0] EXT_FIXED_ONES = 8'hf0;

    // Extended byte fields
    localparam int EXT_CLKFAIL_BIT = 3;
    localparam int EXT_BOD_LSB = 0;
    localparam int EXT_BOD_MSB = 2;

    // High byte fields
    localparam int HIGH_RST_BIT = 7;
    localparam int HIGH_DBG_BIT = 6;
    localparam int HIGH_SPI_BIT = 5;
    localparam int HIGH_WDT_BIT = 4;
    localparam int HIGH_KEEP_BIT = 3;
    localparam int HIGH_BOOTSIZE_LSB = 1;
    localparam int HIGH_BOOTSIZE_MSB = 2;
    localparam int HIGH_RSTVEC_BIT = 0;

    // Low byte fields
    localparam int LOW_DIV8_BIT = 7;
    localparam int LOW_CLKOUT_BIT = 6;
    localparam int LOW_START_LSB = 4;
    localparam int LOW_START_MSB = 5;
    localparam int LOW_CLKSRC_LSB = 0;
    localparam int LOW_CLKSRC_MSB = 3;

    // Lock byte fields
    localparam int LOCK_A_BIT = 0;
    localparam int LOCK_B_BIT = 1;
    localparam int BOOT_LO_BIT = 4;
    localparam int BOOT_HI_BIT = 5;
    localparam logic [7:0] LOCK_BOOT_MASK = 8'h3c;

    // Signature space offsets
    localparam logic [1:0] SIG_OFS0 = 2'h0;
    localparam logic [1:0] SIG_OFS1 = 2'h1;
    localparam logic [1:0] SIG_OFS2 = 2'h2;

    ////////////////////////////////////////////////////////////////
    // Read spaces and fuse selectors
    typedef enum logic [1:0] {
        SPACE_SIG = 2'h0,
        SPACE_FUSE = 2'h1,
        SPACE_LOCK = 2'h2,
        SPACE_CAL = 2'h3
    } flc_space_t;

    typedef enum logic [1:0] {
        FUSE_LOW = 2'h0,
        FUSE_HIGH = 2'h1,
        FUSE_EXT = 2'h2
    } flc_fuse_sel_t;

    // Boot lock modes, Gray ordered
    typedef enum logic [1:0] {
        BMODE1 = 2'b00,
        BMODE2 = 2'b01,
        BMODE3 = 2'b11,
        BMODE4 = 2'b10
    } flc_boot_mode_t;

    // Latch sequencer states
    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_NORMAL = 2'b01,
        ST_PROG = 2'b11,
        ST_EXIT = 2'b10
    } flc_state_t;

endpackage

// ==== testbench/flc_prog_model.sv ====
// Purpose: programmer model driving the fuse and lock write side
// Assumes: strobes last one clock, driven at the falling edge
// Notes: data lines show the inverse once released
`timescale 1ns/1ps
module flc_prog_model (
    input wire logic clk,
    input wire logic inProgMode,
    output logic progModePin,
    output logic serialMode,
    output logic fuseWrStb,
    output flc_pkg::flc_fuse_sel_t fuseWrSel,
    output logic [7:0] fuseWrData,
    output logic lockWrStb,
    output logic [7:0] lockWrData,
    output logic chipEraseStb
);
    import flc_pkg::*;
    // Idle programmer at time zero
    initial begin
        progModePin = 1'b0;
        serialMode = 1'b0;
        fuseWrStb = 1'b0;
        fuseWrSel = FUSE_LOW;
        fuseWrData = 8'h00;
        lockWrStb = 1'b0;
        lockWrData = 8'h00;
        chipEraseStb = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // Mode pin, bounded wait for the filtered mode flag
    task automatic prog(input logic on);
        @(negedge clk);
        progModePin = on;
        for (int i = 0; i < 20 && inProgMode !== on; i++) begin
            @(negedge clk);
        end
    endtask
    // one fuse byte write; the caller also writes after lock bit a to check the freeze
    task automatic fuse_wr(input flc_fuse_sel_t sel, input logic [7:0] d);
        @(negedge clk);
        fuseWrSel = sel;
        fuseWrData = d;
        fuseWrStb = 1'b1;
        @(negedge clk);
        fuseWrStb = 1'b0;
        fuseWrData = ~d; // Released bus, no stale value
    endtask
    // Lock write, or chip erase when er is set
    task automatic lock_wr(input logic er, input logic [7:0] d);
        @(negedge clk);
        lockWrData = d;
        lockWrStb = !er;
        chipEraseStb = er;
        @(negedge clk);
        lockWrStb = 1'b0;
        chipEraseStb = 1'b0;
        lockWrData = ~d;
    endtask
endmodule // flc_prog_model

// ==== testbench/test_fuse_lock_config.sv ====
// Purpose: self-checking bench for the fuse and lock block
// Assumes: reads answered one cycle after the strobe
// Notes: read results queued, combinational checks direct
`timescale 1ns/1ps
module test_fuse_lock_config;
    import flc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic progModePin, serialMode, fuseWrStb, lockWrStb, chipEraseStb, inProgMode;
    flc_fuse_sel_t fuseWrSel;
    logic [7:0] fuseWrData, lockWrData, rdData, rcOscCalibrationReg, oscCalWrData = 8'h00;
    logic rdStb = 1'b0, rdValid, oscCalWrStb = 1'b0;
    flc_space_t rdSpace = SPACE_SIG;
    logic [1:0] rdAddr = 2'h0, bootSizeSel, startupTimeSel;
    logic st = 1'b0, ld = 1'b0, acc = 1'b0, ex = 1'b0, vb = 1'b0;
    logic storeBlocked, loadBlocked, irqDisable, clkFailDis, rstDis, dbg, serial_prog_enable, wdt, keep, rvec, div8, clkOut;
    logic [2:0] bod;
    logic [3:0] clkSrc;
    logic [7:0] expQ[$];
    logic [7:0] modes[4] = '{8'hff, 8'hef, 8'hcf, 8'hdf};
    int badCount = 0, nCompared = 0, cyc = 0;
    logic sb, lb;

    flc_prog_model pm (.clk(clk), .inProgMode(inProgMode), .progModePin(progModePin),
        .serialMode(serialMode), .fuseWrStb(fuseWrStb), .fuseWrSel(fuseWrSel),
        .fuseWrData(fuseWrData), .lockWrStb(lockWrStb), .lockWrData(lockWrData),
        .chipEraseStb(chipEraseStb));
    flc_fuse_lock_config dut (.clk(clk), .reset(reset), .progModePin(progModePin),
        .serialMode(serialMode), .fuseWrStb(fuseWrStb), .fuseWrSel(fuseWrSel),
        .fuseWrData(fuseWrData), .lockWrStb(lockWrStb), .lockWrData(lockWrData),
        .chipEraseStb(chipEraseStb), .rdStb(rdStb), .rdSpace(rdSpace), .rdAddr(rdAddr),
        .rdData(rdData), .rdValid(rdValid), .storeProgramInstr(st), .loadProgramInstr(ld),
        .accessInBoot(acc), .execInBoot(ex), .vectorsInBoot(vb), .storeBlocked(storeBlocked),
        .loadBlocked(loadBlocked), .irqDisable(irqDisable), .oscCalWrStb(oscCalWrStb),
        .oscCalWrData(oscCalWrData), .rcOscCalibrationReg(rcOscCalibrationReg),
        .clockFailDetectDisable(clkFailDis), .brownoutLevelSel(bod), .extResetDisable(rstDis),
        .oneWireDebugEnable(dbg), .serialProgEnable(serial_prog_enable), .watchdogForcedOn(wdt),
        .eepromKeepOnErase(keep), .bootSizeSel(bootSizeSel), .resetVectorSel(rvec),
        .clockDivByEight(div8), .clockOutputEnable(clkOut), .startupTimeSel(startupTimeSel),
        .clockSourceSel(clkSrc), .inProgMode(inProgMode));

    ////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            badCount++;
            testDone();
        end
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic testDone();
        if (badCount == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Read request with its expected byte noted
    task automatic rd(input flc_space_t sp, input logic [1:0] a, input logic [7:0] e);
        @(negedge clk);
        rdSpace = sp;
        rdAddr = a;
        rdStb = 1'b1;
        expQ.push_back(e);
        @(negedge clk);
        rdStb = 1'b0;
    endtask
    // Read monitor, oldest note against the answer
    always @(negedge clk) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() == 0)
                check("rdStray", rdData, 8'hxx);
            else
                check("rdData", rdData, expQ.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h5a299163));
        repeat (4) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        // Shipped defaults decoded on the outputs
        check("cal", rcOscCalibrationReg, 8'h80);
        check("clkFailDis", clkFailDis, 1'b1);
        check("bod", bod, 3'h7);
        check("serial_prog_enable", serial_prog_enable, 1'b1);
        check("rstWdtDbg", {rstDis, wdt, dbg}, 3'h0);
        check("bootSize", {keep, bootSizeSel, rvec}, 4'h1);
        check("clkSrc", clkSrc, 4'h2);
        check("div8clkOut", {div8, clkOut}, 2'h2);
        check("startup", startupTimeSel, 2'h2);
        rd(SPACE_FUSE, 2'h0, 8'h62);
        rd(SPACE_FUSE, 2'h1, 8'hd9);
        rd(SPACE_FUSE, 2'h2, 8'hf7);
        rd(SPACE_SIG, 2'h3, 8'h00);
        rd(SPACE_CAL, 2'h0, 8'h80);
        for (int i = 0; i < 3; i++)
            rd(SPACE_SIG, i[1:0], i == 0 ? 8'h5a : i == 1 ? 8'h3c : 8'h21);
        pm.prog(1'b1);
        check("inProgOn", inProgMode, 1'b1);
        // Boot lock modes against random access patterns
        for (int m = 0; m < 4; m++) begin
            pm.lock_wr(1'b1, 8'hff);
            pm.lock_wr(1'b0, modes[m]);
            repeat (16) begin
                @(negedge clk);
                {st, ld, acc, ex, vb} = 5'($urandom);
                #1;
                sb = st & acc & (m == 1 || m == 2);
                lb = ld & acc & !ex & (m >= 2);
                check("storeBlocked", storeBlocked, sb);
                check("loadBlocked", loadBlocked, lb);
                check("irqDisable", irqDisable, ex & !vb & (m >= 2));
            end
        end
        pm.lock_wr(1'b1, 8'hff);
        pm.fuse_wr(FUSE_LOW, 8'h22);
        rd(SPACE_FUSE, 2'h0, 8'h22);
        check("clkOutHeld", clkOut, 1'b0);
        pm.fuse_wr(FUSE_HIGH, 8'hd1);
        repeat (2) @(negedge clk);
        check("keepNow", keep, 1'b1);
        pm.fuse_wr(FUSE_EXT, 8'h00);
        rd(SPACE_FUSE, 2'h2, 8'hf0);
        pm.serialMode = 1'b1;
        pm.fuse_wr(FUSE_HIGH, 8'hf1);
        rd(SPACE_FUSE, 2'h1, 8'hf1);
        pm.serialMode = 1'b0;
        rd(SPACE_FUSE, 2'h1, 8'hd1);
        pm.lock_wr(1'b1, 8'hff);
        rd(SPACE_FUSE, 2'h0, 8'h22);
        pm.lock_wr(1'b0, 8'hfe);
        pm.fuse_wr(FUSE_LOW, 8'hff);
        rd(SPACE_FUSE, 2'h0, 8'h22);
        pm.lock_wr(1'b0, 8'hff);
        rd(SPACE_LOCK, 2'h0, 8'hfe);
        rd(SPACE_SIG, 2'h1, 8'h3c);
        pm.prog(1'b0);
        repeat (4) @(negedge clk);
        check("clkOutExit", clkOut, 1'b1);
        check("inProgOff", inProgMode, 1'b0);
        check("bodExit", bod, 3'h0);
        check("spiExit", serial_prog_enable, 1'b1);
        // Software calibration write
        oscCalWrData = 8'($urandom);
        oscCalWrStb = 1'b1;
        @(negedge clk);
        oscCalWrStb = 1'b0;
        check("calWr", rcOscCalibrationReg, oscCalWrData);
        repeat (3) @(negedge clk);
        check("rdQueue", 8'(expQ.size()), 8'h00);
        testDone();
    end
endmodule // test_fuse_lock_config
